// >>> hw/pcs_defines.svh
// constants of the six-output modulator: register offsets, field positions, reset values
// assumes byte addresses on a 32-bit register bus, one aligned word per register
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PCS_OFF_CTRL 8'h00
`define PCS_OFF_PRESCALE 8'h04
`define PCS_OFF_PERIOD 8'h08
`define PCS_OFF_SYNC_DELAY 8'h0C
`define PCS_OFF_TRAP_CTRL 8'h10
`define PCS_OFF_STATUS 8'h14
`define PCS_OFF_EVENT 8'h18
`define PCS_OFF_EVENT_EN 8'h1C
`define PCS_OFF_CAP0 8'h20
`define PCS_OFF_CAP1 8'h24
`define PCS_OFF_CAP2 8'h28
`define PCS_OFF_RISE_BASE 3'h2
`define PCS_OFF_FALL_BASE 3'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCS_CTRL_RUN 0
`define PCS_CTRL_ONCE 1
`define PCS_CTRL_BURST 2
`define PCS_CTRL_MASTER 3
`define PCS_CTRL_SLAVE 4
`define PCS_TRAP_EN 6
`define PCS_EV_FALL 6
`define PCS_EV_CAP 12
`define PCS_EV_OVF 15
`define PCS_EV_TRAP 16
`define PCS_PIN_TRAP 3
`define PCS_PIN_SYNC 4
`define PCS_PIN_TRANS 5
`define PCS_PIN_CARRIER 6

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define PCS_RST_CTRL 6'h00
`define PCS_RST_PRESCALE 16'h0000
`define PCS_RST_PERIOD 16'hFFFF
`define PCS_RST_SYNC_DELAY 16'h0000
`define PCS_RST_TRAP_CTRL 7'h00
`define PCS_RESP_OKAY 2'h0
`define PCS_RESP_SLVERR 2'h2

`endif

// >>> hw/pcs_pkg.sv
// types of the six-output modulator
// assumes pcs_defines.svh for all numeric constants
`default_nettype none

package pcs_pkg;

  // ----------------------------------------------------------------
  // whole state of the block, one register
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic awh;
    logic [7:0] awa;
    logic wh;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [5:0] ctrl;
    logic [15:0] psc;
    logic [15:0] per;
    logic [15:0] dly;
    logic [6:0] trapc;
    logic [16:0] ien;
    logic [16:0] ist;
    logic [5:0][15:0] rise;
    logic [5:0][15:0] fall;
    logic pend;
    logic [15:0] psc_sh;
    logic [15:0] per_sh;
    logic [5:0][15:0] rise_sh;
    logic [5:0][15:0] fall_sh;
    logic once_sh;
    logic [15:0] pre;
    logic [15:0] cnt;
    logic running;
    logic run_prev;
    logic trapped;
    logic [5:0] wave;
    logic [5:0] pin;
    logic [2:0][15:0] cap;
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] f;
    logic dbusy;
    logic [15:0] dcnt;
    logic dxfer;
    logic sync_o;
    logic te_o;
    logic irq;
  } pcs_state_t;

endpackage : pcs_pkg

`default_nettype wire

// >>> hw/pcs_top.sv
// six-output modulator with capture, trap, burst mixing and chained synchronisation
// assumes a single 50 MHz clock; pins and chain inputs arrive asynchronously
`timescale 1ns/10ps
`default_nettype none
`include "pcs_defines.svh"

module pcs_top
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // external pins
  input wire logic [2:0] capture_in,
  input wire logic trap_in,
  input wire logic carrier_in,
  // chain inputs from the upstream module
  input wire logic sync_in,
  input wire logic trans_enable_in,
  // modulated outputs
  output logic [5:0] pwm_out,
  // chain outputs to the downstream module
  output logic sync_out,
  output logic trans_enable_out,
  // event request
  output logic irq
);

  pcs_state_t s_q;
  pcs_state_t s_d;

  // ----------------------------------------------------------------
  // byte-lane merge for register writes
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [6:0] fe;
    logic [16:0] ev;
    logic [16:0] clr;
    logic restart;
    logic xfer;
    logic tick;
    logic [31:0] m;
    logic [2:0] idx;
    s_d = s_q;
    fe = 7'h00;
    ev = 17'h00000;
    clr = 17'h00000;
    restart = 1'b0;
    xfer = 1'b0;
    tick = 1'b0;
    m = 32'h00000000;
    idx = 3'h0;
    s_d.sync_o = 1'b0;
    s_d.te_o = 1'b0;

    // pin synchronisers: a level counts once the second and third stages agree
    s_d.s1 = {carrier_in, trans_enable_in, sync_in, trap_in, capture_in};
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < 7; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.f[i] = s_q.s2[i];
      end
    end
    fe = s_d.f & ~s_q.f;

    // start, stop and slave restart
    s_d.run_prev = s_q.ctrl[`PCS_CTRL_RUN];
    if (!s_q.ctrl[`PCS_CTRL_RUN]) begin
      s_d.running = 1'b0;
    end
    if (s_q.ctrl[`PCS_CTRL_RUN] && !s_q.run_prev) begin
      restart = 1'b1;
    end
    if (s_q.ctrl[`PCS_CTRL_SLAVE] && fe[`PCS_PIN_SYNC]) begin
      restart = s_q.ctrl[`PCS_CTRL_RUN];
    end
    if (s_q.ctrl[`PCS_CTRL_SLAVE] && fe[`PCS_PIN_TRANS]) begin
      xfer = 1'b1;
    end

    // prescaler and period counter
    if (s_q.running) begin
      if (s_q.pre == s_q.psc_sh) begin
        s_d.pre = 16'h0000;
        tick = 1'b1;
      end else begin
        s_d.pre = s_q.pre + 16'h0001;
      end
    end
    if (tick) begin
      if (s_q.cnt == s_q.per_sh) begin
        ev[`PCS_EV_OVF] = 1'b1;
        s_d.cnt = 16'h0000;
        if (s_q.once_sh) begin
          s_d.running = 1'b0;
        end else begin
          restart = 1'b1;
        end
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
    if (restart) begin
      s_d.cnt = 16'h0000;
      s_d.pre = 16'h0000;
      s_d.running = 1'b1;
      if (s_q.pend && !s_q.ctrl[`PCS_CTRL_SLAVE]) begin
        xfer = 1'b1;
      end
    end

    // shadow transfer into the counter side
    if (xfer) begin
      s_d.psc_sh = s_q.psc;
      s_d.per_sh = s_q.per;
      s_d.rise_sh = s_q.rise;
      s_d.fall_sh = s_q.fall;
      s_d.once_sh = s_q.ctrl[`PCS_CTRL_ONCE];
      s_d.pend = 1'b0;
    end

    // edge placement per output, falling wins on equal counts; fresh shadows apply at restart
    if (tick || restart) begin
      for (int i = 0; i < 6; i++) begin
        if (s_d.cnt == s_d.rise_sh[i]) begin
          s_d.wave[i] = 1'b1;
          ev[i] = 1'b1;
        end
        if (s_d.cnt == s_d.fall_sh[i]) begin
          s_d.wave[i] = 1'b0;
          ev[`PCS_EV_FALL + i] = 1'b1;
        end
      end
    end

    // captures
    for (int c = 0; c < 3; c++) begin
      if (fe[c]) begin
        s_d.cap[c] = s_q.cnt;
        ev[`PCS_EV_CAP + c] = 1'b1;
      end
    end

    // trap entry
    if (s_q.trapc[`PCS_TRAP_EN] && fe[`PCS_PIN_TRAP]) begin
      s_d.trapped = 1'b1;
      ev[`PCS_EV_TRAP] = 1'b1;
    end

    // delayed master pulses; a new start reloads the delay
    if (s_q.dbusy) begin
      if (s_q.dcnt == 16'h0000) begin
        s_d.dbusy = 1'b0;
        s_d.sync_o = s_q.ctrl[`PCS_CTRL_MASTER];
        s_d.te_o = s_q.ctrl[`PCS_CTRL_MASTER] & s_q.dxfer;
      end else begin
        s_d.dcnt = s_q.dcnt - 16'h0001;
      end
    end
    if (restart) begin
      s_d.dbusy = 1'b1;
      s_d.dcnt = s_q.dly;
      s_d.dxfer = xfer;
    end

    // bus: address and data taken in either order
    if (awvalid && s_q.awrdy) begin
      s_d.awh = 1'b1;
      s_d.awa = awaddr;
    end
    if (wvalid && s_q.wrdy) begin
      s_d.wh = 1'b1;
      s_d.wd = wdata;
      s_d.ws = wstrb;
    end
    if (bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.awh && s_q.wh && !s_q.bvalid) begin
      s_d.awh = 1'b0;
      s_d.wh = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `PCS_RESP_OKAY;
      idx = s_q.awa[4:2];
      case (s_q.awa)
        `PCS_OFF_CTRL: begin
          m = merge({26'h0, s_q.ctrl}, s_q.wd, s_q.ws);
          s_d.ctrl = m[5:0];
          s_d.pend = 1'b1;
        end
        `PCS_OFF_PRESCALE: begin
          m = merge({16'h0, s_q.psc}, s_q.wd, s_q.ws);
          s_d.psc = m[15:0];
          s_d.pend = 1'b1;
        end
        `PCS_OFF_PERIOD: begin
          m = merge({16'h0, s_q.per}, s_q.wd, s_q.ws);
          s_d.per = m[15:0];
          s_d.pend = 1'b1;
        end
        `PCS_OFF_SYNC_DELAY: begin
          m = merge({16'h0, s_q.dly}, s_q.wd, s_q.ws);
          s_d.dly = m[15:0];
        end
        `PCS_OFF_TRAP_CTRL: begin
          m = merge({25'h0, s_q.trapc}, s_q.wd, s_q.ws);
          s_d.trapc = m[6:0];
        end
        `PCS_OFF_EVENT: begin
          m = merge(32'h00000000, s_q.wd, s_q.ws);
          clr = m[16:0];
          if (clr[`PCS_EV_TRAP] && !s_q.f[`PCS_PIN_TRAP] && !ev[`PCS_EV_TRAP]) begin
            s_d.trapped = 1'b0;
          end
        end
        `PCS_OFF_EVENT_EN: begin
          m = merge({15'h0, s_q.ien}, s_q.wd, s_q.ws);
          s_d.ien = m[16:0];
        end
        default: begin
          if (s_q.awa[7:5] == `PCS_OFF_RISE_BASE && idx < 3'h6 && s_q.awa[1:0] == 2'h0) begin
            m = merge({16'h0, s_q.rise[idx]}, s_q.wd, s_q.ws);
            s_d.rise[idx] = m[15:0];
            s_d.pend = 1'b1;
          end else if (s_q.awa[7:5] == `PCS_OFF_FALL_BASE && idx < 3'h6
                       && s_q.awa[1:0] == 2'h0) begin
            m = merge({16'h0, s_q.fall[idx]}, s_q.wd, s_q.ws);
            s_d.fall[idx] = m[15:0];
            s_d.pend = 1'b1;
          end else begin
            s_d.bresp = `PCS_RESP_SLVERR;
          end
        end
      endcase
    end

    // event flags: a new event wins over a clear in the same cycle
    s_d.ist = (s_q.ist & ~clr) | ev;
    s_d.irq = |(s_d.ist & s_d.ien);

    // bus: read
    if (rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arrdy) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `PCS_RESP_OKAY;
      s_d.rdata = 32'h00000000;
      idx = araddr[4:2];
      case (araddr)
        `PCS_OFF_CTRL: s_d.rdata = {26'h0, s_q.ctrl};
        `PCS_OFF_PRESCALE: s_d.rdata = {16'h0, s_q.psc};
        `PCS_OFF_PERIOD: s_d.rdata = {16'h0, s_q.per};
        `PCS_OFF_SYNC_DELAY: s_d.rdata = {16'h0, s_q.dly};
        `PCS_OFF_TRAP_CTRL: s_d.rdata = {25'h0, s_q.trapc};
        `PCS_OFF_STATUS: s_d.rdata = {s_q.cnt, 13'h0, s_q.pend, s_q.trapped, s_q.running};
        `PCS_OFF_EVENT: s_d.rdata = {15'h0, s_q.ist};
        `PCS_OFF_EVENT_EN: s_d.rdata = {15'h0, s_q.ien};
        `PCS_OFF_CAP0: s_d.rdata = {16'h0, s_q.cap[0]};
        `PCS_OFF_CAP1: s_d.rdata = {16'h0, s_q.cap[1]};
        `PCS_OFF_CAP2: s_d.rdata = {16'h0, s_q.cap[2]};
        default: begin
          if (araddr[7:5] == `PCS_OFF_RISE_BASE && idx < 3'h6 && araddr[1:0] == 2'h0) begin
            s_d.rdata = {16'h0, s_q.rise[idx]};
          end else if (araddr[7:5] == `PCS_OFF_FALL_BASE && idx < 3'h6
                       && araddr[1:0] == 2'h0) begin
            s_d.rdata = {16'h0, s_q.fall[idx]};
          end else begin
            s_d.rresp = `PCS_RESP_SLVERR;
          end
        end
      endcase
    end
    s_d.awrdy = ~s_d.awh & ~s_d.bvalid;
    s_d.wrdy = ~s_d.wh & ~s_d.bvalid;
    s_d.arrdy = ~s_d.rvalid;

    // output pins: trap levels, else waveform gated by carrier in burst mode
    for (int i = 0; i < 6; i++) begin
      if (s_d.trapped) begin
        s_d.pin[i] = s_q.trapc[i];
      end else if (s_q.ctrl[`PCS_CTRL_BURST]) begin
        s_d.pin[i] = s_d.wave[i] & s_d.f[`PCS_PIN_CARRIER];
      end else begin
        s_d.pin[i] = s_d.wave[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.ctrl <= `PCS_RST_CTRL;
      s_q.psc <= `PCS_RST_PRESCALE;
      s_q.per <= `PCS_RST_PERIOD;
      s_q.dly <= `PCS_RST_SYNC_DELAY;
      s_q.trapc <= `PCS_RST_TRAP_CTRL;
      s_q.psc_sh <= `PCS_RST_PRESCALE;
      s_q.per_sh <= `PCS_RST_PERIOD;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready = s_q.awrdy;
  assign wready = s_q.wrdy;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arrdy;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign pwm_out = s_q.pin;
  assign sync_out = s_q.sync_o;
  assign trans_enable_out = s_q.te_o;
  assign irq = s_q.irq;

endmodule : pcs_top

`default_nettype wire

// >>> test/pcs_monitor.sv
// checker of the modulator's bus handshakes and chain pulses
// assumes it is bound to pcs_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none

module pcs_monitor
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  // chain outputs
  input wire logic sync_out,
  input wire logic trans_enable_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_wr_answer;
    !awready && !wready ##[0:1] bvalid;
  endsequence
  property p_wr_walk;
    s_wr_taken |=> s_wr_answer;
  endproperty
  a_wr_walk: assert property (p_wr_walk) else $error("write not answered");
  property p_b_back;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_back: assert property (p_b_back) else $error("write slot not reopened");
  property p_b_excl;
    bvalid |-> !awready && !wready;
  endproperty
  a_b_excl: assert property (p_b_excl) else $error("write taken during answer");
  property p_r_walk;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_r_walk: assert property (p_r_walk) else $error("read not answered");
  property p_r_done;
    rvalid && rready |=> !rvalid && arready;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read slot not reopened");
  property p_r_excl;
    rvalid |-> !arready;
  endproperty
  a_r_excl: assert property (p_r_excl) else $error("read taken during answer");
  property p_sync_one;
    sync_out |=> !sync_out;
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("sync pulse too long");
  property p_te_sync;
    trans_enable_out |-> sync_out;
  endproperty
  a_te_sync: assert property (p_te_sync) else $error("transfer pulse without sync");
endmodule : pcs_monitor

bind pcs_top pcs_monitor pcs_monitor_i (.clk, .reset_n, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .sync_out, .trans_enable_out);
`default_nettype wire

// >>> test/pcs_chain_model.sv
// upstream chain neighbour and carrier source
// assumes the bench calls its tasks from one process
`timescale 1ns/10ps
`default_nettype none

module pcs_chain_model (
  // clock
  input wire logic clk,
  // towards the block
  output logic sync_in,
  output logic trans_enable_in,
  output logic carrier_in
);
  initial begin
    sync_in = 1'b0;
    trans_enable_in = 1'b0;
    carrier_in = 1'b0;
  end

  // held three cycles so the block's input filter accepts them
  task automatic chain_pulse(input logic sync_p, input logic te_p);
    @(posedge clk);
    sync_in <= sync_p;
    trans_enable_in <= te_p;
    repeat (3) @(posedge clk);
    sync_in <= 1'b0;
    trans_enable_in <= 1'b0;
  endtask : chain_pulse

  task automatic set_carrier(input logic lvl);
    @(posedge clk);
    carrier_in <= lvl;
  endtask : set_carrier
endmodule : pcs_chain_model
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench of the six-output modulator
// assumes pcs_top with its bound checker and the chain model
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, trap_in, te;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0] wstrb;
  logic [2:0] awprot, arprot, capture_in;
  logic [1:0] r;
  logic [15:0] c[3];
  wire logic awready, wready, bvalid, arready, rvalid, sync_in, trans_enable_in, carrier_in;
  wire logic sync_out, trans_enable_out, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [5:0] pwm_out;
  int errors, comparisons, t, t0, n, hi[6];

  pcs_top pcs_top_i (.clk, .reset_n, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
    .rready, .rdata, .rresp, .capture_in, .trap_in, .carrier_in, .sync_in, .trans_enable_in,
    .pwm_out, .sync_out, .trans_enable_out, .irq);
  pcs_chain_model pcs_chain_model_i (.clk, .sync_in, .trans_enable_in, .carrier_in);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        rs = rresp;
        done = 1'b1;
      end
    end
  endtask : rd

  // cycles until the next sync pulse, bounded
  task automatic wait_sync();
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (!sync_out && t < 3000);
    te = trans_enable_out;
  endtask : wait_sync

  task automatic count_high(input int cycles);
    for (int k = 0; k < 6; k++) hi[k] = 0;
    repeat (cycles) begin
      @(posedge clk);
      for (int k = 0; k < 6; k++) hi[k] += pwm_out[k];
    end
  endtask : count_high

  task automatic s_regs();
    logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
    logic [31:0] e[6] = '{32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0};
    for (int k = 0; k < 6; k++) begin
      rd(a[k], d, r);
      chk("reset value", d, e[k]);
    end
    rd(8'h2C, d, r);
    chk("unmapped read", r, 2);
    wr(8'h2C, 32'h1, r);
    chk("unmapped write", r, 2);
  endtask : s_regs

  task automatic s_period();
    wr(8'h08, 32'h9, r);
    for (int k = 0; k < 6; k++) begin
      wr(8'h40 + 8'(4 * k), 32'(k), r);
      wr(8'h60 + 8'(4 * k), 32'(k + 3), r);
    end
    wr(8'h18, 32'h1FFFF, r);
    wr(8'h00, 32'h9, r);
    wait_sync();
    chk("te at start", te, 1);
    wait_sync();
    chk("sync spacing", t, 10);
    chk("te without load", te, 0);
    count_high(10);
    for (int k = 0; k < 6; k++) chk("high cycles", hi[k], 3);
    rd(8'h18, d, r);
    chk("events", d[16:0], 17'h08FFF);
    wr(8'h04, 32'h2, r);
    rd(8'h14, d, r);
    chk("pending", d[2], 1);
    wait_sync();
    chk("te on load", te, 1);
    wait_sync();
    chk("prescaled spacing", t, 30);
    wr(8'h04, 32'h0, r);
  endtask : s_period

  task automatic s_delay();
    wr(8'h00, 32'h0, r);
    wr(8'h00, 32'h9, r);
    wait_sync();
    t0 = t;
    wr(8'h00, 32'h0, r);
    wr(8'h0C, 32'h5, r);
    wr(8'h00, 32'h9, r);
    wait_sync();
    chk("sync delay", t - t0, 5);
    wr(8'h0C, 32'h0, r);
  endtask : s_delay

  task automatic s_once();
    wr(8'h00, 32'h0, r);
    wr(8'h00, 32'hB, r);
    n = 0;
    repeat (60) begin
      @(posedge clk);
      n += sync_out;
    end
    chk("one period", n, 1);
    rd(8'h14, d, r);
    chk("stopped", d[0], 0);
  endtask : s_once

  task automatic s_trap();
    wr(8'h00, 32'h0, r);
    wr(8'h00, 32'h9, r);
    wr(8'h10, 32'h6A, r);
    trap_in <= 1'b1;
    repeat (8) @(posedge clk);
    count_high(10);
    for (int k = 0; k < 6; k++) chk("trap level", hi[k], (k % 2) * 10);
    rd(8'h18, d, r);
    chk("trap event", d[16], 1);
    trap_in <= 1'b0;
    repeat (6) @(posedge clk);
    wr(8'h18, 32'h10000, r);
    rd(8'h14, d, r);
    chk("trap released", d[1], 0);
    wr(8'h10, 32'h0, r);
  endtask : s_trap

  task automatic s_capture();
    wr(8'h00, 32'h0, r);
    wr(8'h08, 32'hFFFF, r);
    wr(8'h1C, 32'h7000, r);
    wr(8'h18, 32'h1FFFF, r);
    wr(8'h00, 32'h1, r);
    for (int k = 0; k < 3; k++) begin
      capture_in[k] <= 1'b1;
      repeat (100) @(posedge clk);
    end
    chk("capture irq", irq, 1);
    for (int k = 0; k < 3; k++) begin
      rd(8'h20 + 8'(4 * k), d, r);
      c[k] = d[15:0];
    end
    chk("capture spacing", 16'(c[1] - c[0]), 100);
    chk("capture spacing", 16'(c[2] - c[1]), 100);
    rd(8'h18, d, r);
    chk("capture events", d[14:12], 7);
    wr(8'h18, 32'h7000, r);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 0);
    capture_in <= 3'h0;
  endtask : s_capture

  task automatic s_burst();
    wr(8'h00, 32'h0, r);
    wr(8'h08, 32'h9, r);
    wr(8'h00, 32'h5, r);
    for (int lv = 0; lv < 2; lv++) begin
      pcs_chain_model_i.set_carrier(lv[0]);
      repeat (6) @(posedge clk);
      count_high(20);
      for (int k = 0; k < 6; k++) chk("burst high", hi[k], lv * 6);
    end
  endtask : s_burst

  task automatic s_slave();
    wr(8'h00, 32'h0, r);
    wr(8'h08, 32'hFFFF, r);
    wr(8'h00, 32'h9, r);
    wr(8'h00, 32'h19, r);
    wr(8'h08, 32'h9, r);
    pcs_chain_model_i.chain_pulse(1'b1, 1'b1);
    wait_sync();
    chk("slave restart", t < 12, 1);
    wait_sync();
    chk("slave period", t, 10);
  endtask : s_slave

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    {reset_n, awvalid, wvalid, arvalid, trap_in, awaddr, araddr, wdata} = '0;
    {awprot, arprot, capture_in} = '0;
    {bready, rready, wstrb} = 6'h3F;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    s_regs();
    s_period();
    s_delay();
    s_once();
    s_trap();
    s_capture();
    s_burst();
    s_slave();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
